// File: verilog/cu_defines.vh
// Register offsets, field positions, reset values and timing counts of the coherency unit bank
`ifndef CU_DEFINES_VH
`define CU_DEFINES_VH

// Register byte offsets from the peripheral base
`define CU_OFF_PWR_STATUS 13'h0008
`define CU_OFF_WAY_INVAL 13'h000C
`define CU_OFF_M1_FILT_START 13'h0040
`define CU_OFF_M1_FILT_END 13'h0044
`define CU_OFF_PP_FILT_START 13'h0048
`define CU_OFF_PP_FILT_END 13'h004C
`define CU_OFF_ACCESS_CTRL 13'h0050
`define CU_OFF_ERR_BANK_FIRST 13'h0060

// Decoded address width inside the 8 KB region
`define CU_ADDR_W 13

// Filter address field, 1 MB granularity
`define CU_FILT_MSB 31
`define CU_FILT_LSB 20
`define CU_FILT_W 12

// Power status fields, one two-bit field per core
`define CU_PWR_C0_LSB 0
`define CU_PWR_C1_LSB 8
`define CU_PWR_C2_LSB 16
`define CU_PWR_C3_LSB 24
`define CU_PWR_MASK 32'h03030303
`define CU_PWR_RESET 32'h00000000
`define CU_PWR_DORMANT 2'h2
`define CU_PWR_OFF 2'h3
`define CU_PWR_IDLE_CODE 2'h0

// Way invalidation fields
`define CU_INV_C0_LSB 0
`define CU_INV_C1_LSB 4

// Access control
`define CU_ACC_W 4
`define CU_ACC_RESET 4'hF

// Error bank first entry, core 0 ways at the low end
`define CU_ERR_LSB 16
`define CU_ERR_W 16

// Core count encoding: 0 means one core
`define CU_ONE_CORE 2'h0

// Edges after reset release before straps are captured (sync depth)
`define CU_STRAP_SETTLE 2'h2

// AHB-Lite codes
`define CU_HSIZE_WORD 3'h2
`define CU_HRESP_OKAY 1'h0

`endif

// File: verilog/cu_ahb_slave.v
// AHB-Lite slave front end with one wait state per transfer
`include "cu_defines.vh"
`default_nettype none

module cu_ahb_slave (
    input wire i_core_clk,                  // Core clock
    input wire i_rst_b,                     // Async reset, active low
    input wire i_hsel,                      // Slave select
    input wire [31:0] i_haddr,              // Address
    input wire [1:0] i_htrans,              // Transfer type
    input wire i_hwrite,                    // Write when high
    input wire [2:0] i_hsize,               // Transfer size
    input wire i_hready,                    // Bus ready
    input wire [1:0] i_hmaster_core,        // Issuing core number
    input wire [31:0] i_rdata,              // Read data from the bank
    output reg o_hreadyout,                 // Slave ready
    output reg o_hresp,                     // Response, always OKAY
    output reg [31:0] o_hrdata,             // Read data
    output wire o_req,                      // Data phase strobe
    output wire o_req_write,                // Strobe is a word write
    output wire [`CU_ADDR_W-1:0] o_req_addr, // Latched address
    output wire [1:0] o_req_core            // Latched core number
);

    reg pend_q;
    reg wr_q;
    reg [`CU_ADDR_W-1:0] addr_q;
    reg [1:0] core_q;
    wire take;

    // NONSEQ or SEQ with ready high starts a transfer
    assign take = i_hsel & i_htrans[1] & i_hready;

    assign o_req = pend_q;
    assign o_req_write = wr_q;
    assign o_req_addr = addr_q;
    assign o_req_core = core_q;

    // Wait state lets a write land before a following read is sampled
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pend_q <= 1'b0;
            wr_q <= 1'b0;
            addr_q <= {`CU_ADDR_W{1'b0}};
            core_q <= 2'h0;
            o_hreadyout <= 1'b1;
            o_hresp <= `CU_HRESP_OKAY;
            o_hrdata <= 32'h00000000;
        end else begin
            o_hresp <= `CU_HRESP_OKAY;
            if (pend_q) begin
                pend_q <= 1'b0;
                o_hreadyout <= 1'b1;
                o_hrdata <= wr_q ? 32'h00000000 : i_rdata;
            end else if (take) begin
                pend_q <= 1'b1;
                // Sub-word writes are dropped, the bank is word only
                wr_q <= i_hwrite & (i_hsize == `CU_HSIZE_WORD);
                addr_q <= i_haddr[`CU_ADDR_W-1:0];
                core_q <= i_hmaster_core;
                o_hreadyout <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// File: verilog/cu_pwr_ctrl.v
// Per-core power control output bus, live only while the core sleeps
`include "cu_defines.vh"
`default_nettype none

module cu_pwr_ctrl (
    input wire i_core_clk,            // Core clock
    input wire i_rst_b,               // Async reset, active low
    input wire [3:0] i_core_wfi,      // Core in wait-for-interrupt state
    input wire [31:0] i_pwr_status,   // Power status register
    output reg [7:0] o_core_power_ctrl_out // Two bits per core
);

    integer k;

    // Field forwarded only in WAIT_FOR_INTERRUPT_STATE, else the powered-on code
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_core_power_ctrl_out <= 8'h00;
        end else begin
            for (k = 0; k < 4; k = k + 1) begin
                if (i_core_wfi[k]) begin
                    o_core_power_ctrl_out[2*k +: 2] <= i_pwr_status[8*k +: 2];
                end else begin
                    o_core_power_ctrl_out[2*k +: 2] <= `CU_PWR_IDLE_CODE;
                end
            end
        end
    end

endmodule

`default_nettype wire

// File: verilog/cu_config_regs.v
// Coherency unit register bank: power status, invalidation, filters, access control
//
// Chosen here: register access over AHB-Lite.
`include "cu_defines.vh"
`default_nettype none

// Summary of operation
// - Power status write needs core access bit
// - Status fields at 25:24, 17:16, 9:8, 1:0
// - 0X on, 10 dormant, 11 powered off
// - Status bits tell power controller domains
// - In WAIT_FOR_INTERRUPT_STATE the power control bus enabled
// - Power status reads zero for a core without its access bit
// - Way bits per core; core1 needs two cores
// - Master1 start from input at reset exit
// - Master1 range routes only when filtering, two-port
// - Single port: master1 filters read zero, ignore writes
// - Master1 end from input at reset exit
// - End megabyte included in range
// - Peripheral start from input at reset exit
// - Peripheral end from input at reset exit
// - Access control gates listed registers per core
// - Bits 0-3 per core, one grants, default
// - Error bank ways, core 3 at top
// - Filter enable strap sampled at reset release
module cu_config_regs (
    input wire i_core_clk,                // Core clock, 20 MHz
    input wire i_rst_b,                   // Async reset, active low
    input wire i_hsel,                    // AHB slave select
    input wire [31:0] i_haddr,            // AHB address
    input wire [1:0] i_htrans,            // AHB transfer type
    input wire i_hwrite,                  // AHB write
    input wire [2:0] i_hsize,             // AHB size
    input wire i_hready,                  // AHB ready
    input wire [31:0] i_hwdata,           // AHB write data
    input wire [1:0] i_hmaster_core,      // Core issuing the transfer
    output wire o_hreadyout,              // AHB slave ready
    output wire o_hresp,                  // AHB response
    output wire [31:0] o_hrdata,          // AHB read data
    input wire [11:0] i_master1_range_start_in, // Master1 start strap
    input wire [11:0] i_master1_range_end_in,   // Master1 end strap
    input wire [11:0] i_periph_range_start_in,  // Peripheral start strap
    input wire [11:0] i_periph_range_end_in,    // Peripheral end strap
    input wire i_master_range_filter_en_in,     // Filter enable strap
    input wire i_two_master_ports,        // Second master port built
    input wire [1:0] i_core_count,        // Cores present minus one
    input wire [3:0] i_core_wfi,          // Cores in WAIT_FOR_INTERRUPT_STATE state
    input wire [15:0] i_err_bank_ways,    // Error bank first entry ways
    input wire [31:0] i_route_addr,       // Address to route
    output reg o_route_master1,           // Address goes to master port 1
    output reg o_route_periph,            // Address goes to peripheral port
    output wire [7:0] o_core_power_ctrl_out, // Power controller bus
    output reg [7:0] o_inval_ways,        // Ways to invalidate, cores 1..0
    output reg o_inval_strobe,            // One-cycle invalidate request
    output reg o_filter_enabled           // Address filtering live
);

    // Width of all strap bits gathered for synchronising
    localparam STRAP_W = 4 * `CU_FILT_W + 4;

    // Strap synchroniser and capture
    reg [STRAP_W-1:0] strap_meta_q;
    reg [STRAP_W-1:0] strap_sync_q;
    reg [1:0] settle_q;
    reg captured_q;
    wire [STRAP_W-1:0] strap_in;

    // Captured configuration
    reg [`CU_FILT_W-1:0] m1_start_q;
    reg [`CU_FILT_W-1:0] m1_end_q;
    reg [`CU_FILT_W-1:0] pp_start_q;
    reg [`CU_FILT_W-1:0] pp_end_q;
    reg two_port_q;
    reg [1:0] core_count_q;

    // Software state
    reg [31:0] pwr_status_q;
    reg [`CU_ACC_W-1:0] access_q;
    reg [`CU_ERR_W-1:0] err_ways_q;

    // Bus front end wiring
    wire req;
    wire req_write;
    wire [`CU_ADDR_W-1:0] req_addr;
    wire [1:0] req_core;
    reg [31:0] rdata;
    wire core_ok;
    wire wr_ok;

    // Inclusive megabyte range test shared by both routes
    function in_range;
        input [`CU_FILT_W-1:0] mb;
        input [`CU_FILT_W-1:0] lo;
        input [`CU_FILT_W-1:0] hi;
        begin
            in_range = (mb >= lo) && (mb <= hi);
        end
    endfunction

    // Place a megabyte field in the top of a word
    function [31:0] filt_word;
        input [`CU_FILT_W-1:0] mb;
        begin
            filt_word = {mb, 20'h00000};
        end
    endfunction

    assign strap_in = {i_master1_range_start_in, i_master1_range_end_in,
                       i_periph_range_start_in, i_periph_range_end_in,
                       i_master_range_filter_en_in, i_two_master_ports, i_core_count};

    // Two-flop synchroniser, straps come from outside the domain
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            strap_meta_q <= {STRAP_W{1'b0}};
            strap_sync_q <= {STRAP_W{1'b0}};
        end else begin
            strap_meta_q <= strap_in;
            strap_sync_q <= strap_meta_q;
        end
    end

    // Capture straps once the synchroniser has filled after release
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            settle_q <= 2'h0;
            captured_q <= 1'b0;
            m1_start_q <= {`CU_FILT_W{1'b0}};
            m1_end_q <= {`CU_FILT_W{1'b0}};
            pp_start_q <= {`CU_FILT_W{1'b0}};
            pp_end_q <= {`CU_FILT_W{1'b0}};
            two_port_q <= 1'b0;
            core_count_q <= `CU_ONE_CORE;
            o_filter_enabled <= 1'b0;
        end else if (!captured_q) begin
            if (settle_q == `CU_STRAP_SETTLE) begin
                captured_q <= 1'b1;
                two_port_q <= strap_sync_q[2];
                core_count_q <= strap_sync_q[1:0];
                // Master filters exist only with the second port
                if (strap_sync_q[2]) begin
                    m1_start_q <= strap_sync_q[STRAP_W-1 -: `CU_FILT_W];
                    m1_end_q <= strap_sync_q[STRAP_W-13 -: `CU_FILT_W];
                end
                pp_start_q <= strap_sync_q[STRAP_W-25 -: `CU_FILT_W];
                pp_end_q <= strap_sync_q[STRAP_W-37 -: `CU_FILT_W];
                // Filtering forced off without the second port
                o_filter_enabled <= strap_sync_q[3] & strap_sync_q[2];
            end else begin
                settle_q <= settle_q + 2'h1;
            end
        end
    end

    cu_ahb_slave u_ahb (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_hsel(i_hsel),
        .i_haddr(i_haddr),
        .i_htrans(i_htrans),
        .i_hwrite(i_hwrite),
        .i_hsize(i_hsize),
        .i_hready(i_hready),
        .i_hmaster_core(i_hmaster_core),
        .i_rdata(rdata),
        .o_hreadyout(o_hreadyout),
        .o_hresp(o_hresp),
        .o_hrdata(o_hrdata),
        .o_req(req),
        .o_req_write(req_write),
        .o_req_addr(req_addr),
        .o_req_core(req_core)
    );

    // Per-core permission of the issuing core
    assign core_ok = access_q[req_core];
    assign wr_ok = req & req_write & core_ok;

    // Read mux; gated registers read zero for a denied core
    always @* begin
        rdata = 32'h00000000;
        case (req_addr)
            `CU_OFF_PWR_STATUS: begin
                if (core_ok) begin
                    rdata = pwr_status_q;
                end
            end
            `CU_OFF_M1_FILT_START: begin
                rdata = two_port_q ? filt_word(m1_start_q) : 32'h00000000;
            end
            `CU_OFF_M1_FILT_END: begin
                rdata = two_port_q ? filt_word(m1_end_q) : 32'h00000000;
            end
            `CU_OFF_PP_FILT_START: begin
                rdata = filt_word(pp_start_q);
            end
            `CU_OFF_PP_FILT_END: begin
                rdata = filt_word(pp_end_q);
            end
            `CU_OFF_ACCESS_CTRL: begin
                rdata = {28'h0000000, access_q};
            end
            `CU_OFF_ERR_BANK_FIRST: begin
                if (core_ok) begin
                    rdata = {err_ways_q, 16'h0000};
                end
            end
            default: begin
                rdata = 32'h00000000;
            end
        endcase
    end

    // Power status and access control; denied writes leave power status alone
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pwr_status_q <= `CU_PWR_RESET;
            access_q <= `CU_ACC_RESET;
        end else begin
            if (wr_ok && req_addr == `CU_OFF_PWR_STATUS) begin
                // Reserved bits are never stored
                pwr_status_q <= i_hwdata & `CU_PWR_MASK;
            end
            // Access control itself is not gated, else a lockout is permanent
            if (req && req_write && req_addr == `CU_OFF_ACCESS_CTRL) begin
                access_q <= i_hwdata[`CU_ACC_W-1:0];
            end
        end
    end

    // Way invalidation is write-only, issued as a one-cycle strobe
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_inval_ways <= 8'h00;
            o_inval_strobe <= 1'b0;
        end else begin
            o_inval_strobe <= 1'b0;
            if (wr_ok && req_addr == `CU_OFF_WAY_INVAL) begin
                o_inval_strobe <= 1'b1;
                o_inval_ways[`CU_INV_C0_LSB +: 4] <= i_hwdata[`CU_INV_C0_LSB +: 4];
                // Core 1 ways dropped on a single-core build
                if (core_count_q == `CU_ONE_CORE) begin
                    o_inval_ways[`CU_INV_C1_LSB +: 4] <= 4'h0;
                end else begin
                    o_inval_ways[`CU_INV_C1_LSB +: 4] <= i_hwdata[`CU_INV_C1_LSB +: 4];
                end
            end
        end
    end

    // Error bank entry mirrors the ECC logic, read only
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            err_ways_q <= {`CU_ERR_W{1'b0}};
        end else begin
            err_ways_q <= i_err_bank_ways;
        end
    end

    // Route decisions, one cycle after the address is offered
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_route_master1 <= 1'b0;
            o_route_periph <= 1'b0;
        end else begin
            o_route_master1 <= two_port_q & o_filter_enabled &
                in_range(i_route_addr[`CU_FILT_MSB:`CU_FILT_LSB], m1_start_q, m1_end_q);
            // A badly strapped region (start not below end) never matches
            o_route_periph <= (pp_start_q < pp_end_q) &&
                in_range(i_route_addr[`CU_FILT_MSB:`CU_FILT_LSB], pp_start_q, pp_end_q);
        end
    end

    // Status fields reach the power controller only while a core sleeps
    cu_pwr_ctrl u_pwr (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_core_wfi(i_core_wfi),
        .i_pwr_status(pwr_status_q),
        .o_core_power_ctrl_out(o_core_power_ctrl_out)
    );

endmodule

`default_nettype wire

// File: verif/cu_pwr_partner.sv
// Behavioural cores and external power controller on the far side
`default_nettype none
module cu_pwr_partner (
    input wire logic i_core_clk, // Core clock
    input wire logic i_rst_b, // Async reset, active low
    input wire logic [3:0] i_sleep_req, // Cores asked to enter WAIT_FOR_INTERRUPT_STATE
    input wire logic [7:0] i_power_ctrl, // Power bus from the bank
    output var logic [3:0] o_core_wfi, // Cores in WAIT_FOR_INTERRUPT_STATE
    output var logic [3:0] o_dormant, // Domains allowed dormant
    output var logic [3:0] o_off // Domains allowed off
);
    timeunit 1ns;
    timeprecision 1ns;
    // Cores sleep only when the bench asks, after their status write
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) o_core_wfi <= 4'h0;
        else o_core_wfi <= i_sleep_req;
    end
    // Controller decode per field: 0X stays on, 10 dormant, 11 off
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            o_dormant[k] = i_power_ctrl[2*k+1] & ~i_power_ctrl[2*k];
            o_off[k] = &i_power_ctrl[2*k+:2];
        end
    end
endmodule
`default_nettype wire

// File: verif/cu_config_regs_asserts.sv
// Concurrent checks on the coherency unit register bank ports
`include "cu_defines.vh"
`default_nettype none
module cu_config_regs_asserts (
    input wire i_core_clk, // Core clock
    input wire i_rst_b, // Async reset, active low
    input wire i_hsel, // AHB select
    input wire [31:0] i_haddr, // AHB address
    input wire [1:0] i_htrans, // AHB transfer type
    input wire i_hwrite, // AHB write
    input wire [2:0] i_hsize, // AHB size
    input wire i_hready, // AHB ready
    input wire [31:0] i_hwdata, // AHB write data
    input wire o_hreadyout, // Slave ready
    input wire o_hresp, // Response
    input wire [31:0] o_hrdata, // Read data
    input wire [11:0] i_master1_range_start_in, // Master1 start strap
    input wire [11:0] i_master1_range_end_in, // Master1 end strap
    input wire i_two_master_ports, // Second port built
    input wire [3:0] i_core_wfi, // Cores in WAIT_FOR_INTERRUPT_STATE
    input wire [31:0] i_route_addr, // Address to route
    input wire o_route_master1, // Master1 route
    input wire [7:0] o_core_power_ctrl_out, // Power bus
    input wire [7:0] o_inval_ways, // Ways to invalidate
    input wire o_inval_strobe, // Invalidate pulse
    input wire o_filter_enabled // Filtering live
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    logic take;
    logic inv_wr;
    logic [7:0] wfi_mask;
    // Transfer start, and a word write to the invalidate register
    assign take = i_hsel && i_htrans[1] && i_hready;
    assign inv_wr = take && i_hwrite && i_hsize == 3'h2 && i_haddr[12:0] == `CU_OFF_WAY_INVAL;
    assign wfi_mask = {{2{i_core_wfi[3]}}, {2{i_core_wfi[2]}}, {2{i_core_wfi[1]}},
        {2{i_core_wfi[0]}}};
    sequence s_wait;
        !o_hreadyout ##1 o_hreadyout;
    endsequence
    sequence s_rd_m1;
        take && !i_hwrite && i_haddr[12:0] == `CU_OFF_M1_FILT_START;
    endsequence
    hresp_okay_a:
        assert property (o_hresp == 1'b0) else $error("response not OKAY");
    wait_state_a:
        assert property (take |=> s_wait) else $error("wait state shape wrong");
    filt_read_a:
        assert property (s_rd_m1 |=> s_wait ##0 (o_hrdata == (i_two_master_ports ?
            {i_master1_range_start_in, 20'h00000} : 32'h0))) else $error("start read wrong");
    pwr_idle_a:
        assert property (1'b1 |=> (o_core_power_ctrl_out & ~$past(wfi_mask)) == 8'h00)
        else $error("power bus live for awake core");
    route_gate_a:
        assert property (o_route_master1 |-> o_filter_enabled && i_two_master_ports)
        else $error("master1 route while filtering off");
    filt_en_a:
        assert property (o_filter_enabled |-> i_two_master_ports)
        else $error("filtering on in single port build");
    route_incl_a:
        assert property (o_filter_enabled |=> o_route_master1 ==
            ($past(i_route_addr[31:20]) >= i_master1_range_start_in &&
            $past(i_route_addr[31:20]) <= i_master1_range_end_in))
        else $error("master1 range decision wrong");
    inval_pulse_a:
        assert property (o_inval_strobe |=> !o_inval_strobe) else $error("strobe too long");
    inval_cause_a:
        assert property (o_inval_strobe |-> $past(inv_wr, 2) && !$past(o_hreadyout) &&
            o_inval_ways[3:0] == $past(i_hwdata[3:0])) else $error("strobe without write");
endmodule
`default_nettype wire

// File: verif/cu_config_regs_tb.sv
// Self-checking bench for the coherency unit register bank
`default_nettype none
module cu_config_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_b = 0, hsel = 0, hwrite = 0, two_port = 1, fen = 1;
    logic [31:0] haddr = 0, hwdata = 0, route = 0;
    logic [1:0] htrans = 0, hmc = 0, ncore = 2'h3;
    logic [2:0] hsize = 3'h2;
    logic [11:0] m1s = 12'h100, m1e = 12'hFFF, pps = 12'h010, ppe = 12'h020;
    logic [15:0] ways = 16'hC3A5;
    logic [3:0] sleep = 4'h0;
    wire rdy, resp, rm1, rpp, istb, fon;
    wire [31:0] rdata;
    wire [7:0] pctl, iways;
    wire [3:0] wait_for_interrupt_state, dorm, off;
    int bad_count = 0, samples_checked = 0, strobes = 0;
    cu_config_regs dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hready(rdy),
        .i_hwdata(hwdata), .i_hmaster_core(hmc), .o_hreadyout(rdy), .o_hresp(resp),
        .o_hrdata(rdata), .i_master1_range_start_in(m1s), .i_master1_range_end_in(m1e),
        .i_periph_range_start_in(pps), .i_periph_range_end_in(ppe),
        .i_master_range_filter_en_in(fen), .i_two_master_ports(two_port),
        .i_core_count(ncore), .i_core_wfi(wait_for_interrupt_state), .i_err_bank_ways(ways),
        .i_route_addr(route), .o_route_master1(rm1), .o_route_periph(rpp),
        .o_core_power_ctrl_out(pctl), .o_inval_ways(iways), .o_inval_strobe(istb),
        .o_filter_enabled(fon));
    cu_pwr_partner u_far (.i_core_clk(clk), .i_rst_b(rst_b), .i_sleep_req(sleep),
        .i_power_ctrl(pctl), .o_core_wfi(wait_for_interrupt_state), .o_dormant(dorm), .o_off(off));
    // Free-running core clock, 50 ns period
    always #25 clk = ~clk;
    // Count invalidate pulses so a missing or extra one shows
    always @(posedge clk) if (istb === 1'b1) strobes <= strobes + 1;
    task automatic test_done;
        $display("Checked %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One AHB-Lite single word transfer; waits on hready, watchdog ends a hang
    task automatic ahb(input logic [1:0] c, input logic w, input logic [31:0] a,
        input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        hsel <= 1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        hsize <= 3'h2;
        hmc <= c;
        do @(posedge clk); while (rdy !== 1'b1);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (rdy !== 1'b1);
        r = rdata;
    endtask
    task automatic wr(input logic [1:0] c, input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(c, 1'b1, a, d, x);
    endtask
    task automatic rdchk(input logic [1:0] c, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] x;
        ahb(c, 1'b0, a, 32'h0, x);
        check(x, e);
    endtask
    // Straps stay stable across reset and well past release
    task automatic do_reset(input logic tp, input logic [1:0] nc);
        rst_b <= 0;
        two_port <= tp;
        ncore <= nc;
        repeat (20) @(posedge clk);
        rst_b <= 1;
        repeat (6) @(posedge clk);
    endtask
    task automatic rt(input logic [31:0] a, input logic [1:0] e);
        @(posedge clk) route <= a;
        @(posedge clk);
        #1 check({30'h0, rm1, rpp}, {30'h0, e});
    endtask
    task automatic t_reset_vals;
        rdchk(0, 32'h50, 32'hF);
        rdchk(1, 32'h08, 32'h0);
        rdchk(2, 32'h100, 32'h0);
    endtask
    task automatic t_filters;
        check(fon, 1'b1);
        rdchk(0, 32'h40, {m1s, 20'h0});
        rdchk(1, 32'h44, {m1e, 20'h0});
        rdchk(2, 32'h48, {pps, 20'h0});
        rdchk(3, 32'h4C, {ppe, 20'h0});
        wr(0, 32'h40, 32'h0);
        rdchk(0, 32'h40, {m1s, 20'h0});
    endtask
    task automatic t_route;
        rt(32'hFFF00000, 2'h2);
        rt(32'h0FFFFFFF, 2'h0);
        rt(32'h10000000, 2'h2);
        rt(32'h020FFFFF, 2'h1);
        rt(32'h02100000, 2'h0);
        rt(32'h01000000, 2'h1);
    endtask
    // Status write, then sleep: power bus shows each sleeping core's field
    task automatic t_power;
        wr(0, 32'h08, 32'hFFFFFFFF);
        rdchk(1, 32'h08, 32'h03030303);
        wr(0, 32'h08, 32'h03020100);
        rdchk(3, 32'h08, 32'h03020100);
        @(posedge clk) sleep <= 4'hF;
        repeat (3) @(posedge clk);
        #1 check(pctl, 8'hE4);
        check({dorm, off}, 8'h48);
        @(posedge clk) sleep <= 4'h5;
        repeat (3) @(posedge clk);
        #1 check(pctl, 8'h20);
        @(posedge clk) sleep <= 4'h0;
    endtask
    // Core 0 locks itself out; its writes and reads of gated places die
    task automatic t_access;
        int s;
        wr(0, 32'h50, 32'hE);
        rdchk(1, 32'h50, 32'hE);
        wr(0, 32'h08, 32'h0);
        rdchk(1, 32'h08, 32'h03020100);
        rdchk(0, 32'h08, 32'h0);
        s = strobes;
        wr(0, 32'h0C, 32'hFF);
        rdchk(0, 32'h60, 32'h0);
        check(strobes, s);
        wr(0, 32'h50, 32'hF);
    endtask
    task automatic t_inval(input logic [7:0] e);
        int s;
        s = strobes;
        wr(1, 32'h0C, 32'hA5);
        @(posedge clk);
        #1 check(strobes, s + 1);
        check(iways, e);
    endtask
    task automatic t_errbank;
        @(posedge clk) ways <= 16'h5A3C;
        rdchk(2, 32'h60, 32'h5A3C0000);
    endtask
    // Single port, single core build after a second reset
    task automatic t_single;
        do_reset(1'b0, 2'h0);
        check(fon, 1'b0);
        rdchk(0, 32'h08, 32'h0);
        rdchk(0, 32'h40, 32'h0);
        wr(0, 32'h44, 32'hFFF00000);
        rdchk(0, 32'h44, 32'h0);
        rdchk(0, 32'h48, {pps, 20'h0});
        rt(32'hFFF00000, 2'h0);
        t_inval(8'h05);
    endtask
    // Main sequence
    initial begin
        do_reset(1'b1, 2'h3);
        t_reset_vals();
        t_filters();
        t_route();
        t_power();
        t_access();
        t_inval(8'hA5);
        t_errbank();
        t_single();
        test_done();
    end
    // Watchdog at 40000 cycles, far beyond the few hundred cycles the tests need
    initial begin
        #2000000;
        bad_count++;
        test_done();
    end
endmodule
bind cu_config_regs cu_config_regs_asserts u_chk (.i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hready(i_hready), .i_hwdata(i_hwdata),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata),
    .i_master1_range_start_in(i_master1_range_start_in),
    .i_master1_range_end_in(i_master1_range_end_in),
    .i_two_master_ports(i_two_master_ports), .i_core_wfi(i_core_wfi),
    .i_route_addr(i_route_addr), .o_route_master1(o_route_master1),
    .o_core_power_ctrl_out(o_core_power_ctrl_out), .o_inval_ways(o_inval_ways),
    .o_inval_strobe(o_inval_strobe), .o_filter_enabled(o_filter_enabled));
`default_nettype wire
